// ### verilog/pps_sequencer.sv
// Function
// R01 - code 11 selects initialization latch
// R02 - code 00 reference, 01 N counter latch
// R03 - code 10 selects function latch
// R04 - init write also updates function latch
// R05 - init write pulses counter load, pump three-state
// R06 - pulse spares prescaler reference, oscillator buffer
// R07 - first N write after init repulses
// R08 - later N writes give no pulse
// R09 - host writes counter reset 0 in init
// R10 - host order: init, reference, N
// R11 - enable pin low powers down immediately
// R12 - host: enable low, function, ref, N, raise
// R13 - counters restart aligned after enable rises
// R14 - host waits about 1 us bias settle
// R15 - latches kept across enable power-down
// R16 - host: function reset=1, ref, N
// R17 - function reset=0 releases counters
// R18 - reset bit holds counters, pump three-state
// R19 - counter reset never starts synchronous power-down
// R20 - monitor pin selects internal signals, lock included
// R21 - counter reset is word bit 2
// R22 - init pulse triggers synchronous power-down if selected
// R23 - 24 bits on rising clock, strobe transfers
`default_nettype none
module pps_sequencer
(
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic                clk_en,
    input  wire pps_pkg::pps_serial_t serial_in,
    input  wire logic                power_enable,
    input  wire logic                lock_indication,
    input  wire logic                cp_event,
    input  wire logic                ndiv_out,
    input  wire logic                rdiv_out,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    output logic                     counters_load,
    output logic                     cp_three_state,
    output logic                     power_down,
    output logic                     prescaler_ref_on,
    output logic                     osc_buffer_on,
    output logic                     monitor_output_pin,
    output logic [23:0]              ref_latch,
    output logic [23:0]              ncnt_latch
);

    // ==========================================================
    // input synchronisers and serial edges
    // ==========================================================
    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic        en_s1_r;
    logic        en_s2_r;
    logic        sclk_d_r;
    logic        strobe_d_r;
    logic [23:0] shift_r;
    logic [23:0] func_latch_r;
    logic [23:0] ref_latch_r;
    logic [23:0] ncnt_latch_r;
    logic        init_armed_r;
    logic [1:0]  pulse_cnt_r;
    logic        sync_pd_pend_r;
    logic        prog_pd_r;
    logic [3:0]  settle_cnt_r;
    logic        avs_ack_r;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            en_s1_r  <= 1'b0;
            en_s2_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_s1_r <= {serial_in.sclk, serial_in.sdata, serial_in.strobe};
            pin_s2_r <= pin_s1_r;
            en_s1_r  <= power_enable;
            en_s2_r  <= en_s1_r;
        end
    end

    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    assign sclk_s   = pin_s2_r[2];
    assign sdata_s  = pin_s2_r[1];
    assign strobe_s = pin_s2_r[0];

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_d_r   <= 1'b0;
            strobe_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sclk_d_r   <= sclk_s;
            strobe_d_r <= strobe_s;
        end
    end

    logic sclk_rise;
    logic strobe_rise;
    assign sclk_rise   = sclk_s & ~sclk_d_r;
    assign strobe_rise = strobe_s & ~strobe_d_r;

    // ==========================================================
    // input shift register, keeps shifting in power-down
    // ==========================================================
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            shift_r <= pps_pkg::LATCH_RST;
        else if (clk_en && sclk_rise)
            shift_r <= {shift_r[22:0], sdata_s}; // R23
    end

    // ==========================================================
    // latch decode
    // ==========================================================
    function automatic logic sel_is(input logic [23:0] w, input logic [1:0] code);
        sel_is = (w[pps_pkg::CTRL_LSB +: 2] == code);
    endfunction

    logic wr_ref;
    logic wr_ncnt;
    logic wr_func;
    logic wr_init;
    assign wr_ref  = strobe_rise && sel_is(shift_r, pps_pkg::SEL_REF);   // R02
    assign wr_ncnt = strobe_rise && sel_is(shift_r, pps_pkg::SEL_NCNT);  // R02
    assign wr_func = strobe_rise && sel_is(shift_r, pps_pkg::SEL_FUNC);  // R03
    assign wr_init = strobe_rise && sel_is(shift_r, pps_pkg::SEL_INIT);  // R01

    // latches are only cleared by arst_n, never by the enable pin
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            func_latch_r <= pps_pkg::LATCH_RST;
        else if (clk_en && (wr_func || wr_init))
            func_latch_r <= shift_r; // R04 R15
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_latch_r  <= pps_pkg::LATCH_RST;
            ncnt_latch_r <= pps_pkg::LATCH_RST;
        end
        else if (clk_en)
        begin
            if (wr_ref)
                ref_latch_r <= shift_r; // R02 R15
            if (wr_ncnt)
                ncnt_latch_r <= shift_r; // R02 R15
        end
    end

    // ==========================================================
    // internal reset pulse
    // ==========================================================
    logic fire_pulse;
    assign fire_pulse = wr_init || (wr_ncnt && init_armed_r); // R05 R07

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            init_armed_r <= 1'b0;
        else if (clk_en)
        begin
            if (wr_init)
                init_armed_r <= 1'b1; // R07
            else if (wr_ncnt)
                init_armed_r <= 1'b0; // R08
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            pulse_cnt_r <= 2'h0;
        else if (clk_en)
        begin
            if (fire_pulse)
                pulse_cnt_r <= 2'(pps_pkg::PULSE_CYC); // R05
            else if (pulse_cnt_r != 2'h0)
                pulse_cnt_r <= pulse_cnt_r - 2'h1;
        end
    end

    // ==========================================================
    // power-down control
    // ==========================================================
    logic pd_a;
    logic pd_b;
    logic crst;
    assign pd_a = func_latch_r[pps_pkg::PDA_POS];
    assign pd_b = func_latch_r[pps_pkg::PDB_POS];
    assign crst = func_latch_r[pps_pkg::CRST_POS]; // R21

    // programmed power-down: async on write, sync waits a pump event
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_pd_pend_r <= 1'b0;
            prog_pd_r      <= 1'b0;
        end
        else if (clk_en)
        begin
            // judge the init word itself: the latch only takes it on this same edge
            if (wr_init && en_s2_r && shift_r[pps_pkg::PDA_POS] && shift_r[pps_pkg::PDB_POS])
                sync_pd_pend_r <= 1'b1; // R22 R19
            else if (!pd_a)
            begin
                sync_pd_pend_r <= 1'b0;
                prog_pd_r      <= 1'b0;
            end
            else if (!pd_b)
                prog_pd_r <= 1'b1;
            else if (sync_pd_pend_r && cp_event)
            begin
                sync_pd_pend_r <= 1'b0;
                prog_pd_r      <= 1'b1;
            end
        end
    end

    // bias settle count after enable pin release
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            settle_cnt_r <= 4'h0;
        end
        else if (clk_en)
        begin
            if (!en_s2_r)
                settle_cnt_r <= 4'(pps_pkg::SETTLE_CYC);
            else if (settle_cnt_r != 4'h0)
                settle_cnt_r <= settle_cnt_r - 4'h1;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    logic any_pd;
    logic hold_cnt;
    assign any_pd   = ~en_s2_r | prog_pd_r;
    // counters sit at load while down; release is common to both, aligned
    assign hold_cnt = any_pd || crst || (pulse_cnt_r != 2'h0) || fire_pulse; // R05 R13 R17 R18

    logic [2:0] mon_sel;
    logic       mon_val;
    assign mon_sel = func_latch_r[pps_pkg::MON_LSB +: 3];
    always_comb
    begin
        unique case (mon_sel)
            pps_pkg::MON_LOCK: mon_val = lock_indication; // R20
            pps_pkg::MON_NDIV: mon_val = ndiv_out;
            pps_pkg::MON_RDIV: mon_val = rdiv_out;
            pps_pkg::MON_HIGH: mon_val = 1'b1;
            default:           mon_val = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            counters_load      <= 1'b1;
            cp_three_state     <= 1'b1;
            power_down         <= 1'b1;
            prescaler_ref_on   <= 1'b0;
            osc_buffer_on      <= 1'b0;
            monitor_output_pin <= 1'b0;
            ref_latch          <= pps_pkg::LATCH_RST;
            ncnt_latch         <= pps_pkg::LATCH_RST;
        end
        else if (clk_en)
        begin
            counters_load      <= hold_cnt; // R05 R18
            cp_three_state     <= hold_cnt || func_latch_r[pps_pkg::CPTRI_POS]; // R05 R18
            power_down         <= any_pd; // R11 R19
            // reference and buffer follow only power state, not the pulse
            prescaler_ref_on   <= ~any_pd; // R06
            osc_buffer_on      <= ~any_pd; // R06
            monitor_output_pin <= mon_val;
            ref_latch          <= ref_latch_r;
            ncnt_latch         <= ncnt_latch_r;
        end
    end

    // ==========================================================
    // avalon slave, one wait state per access
    // ==========================================================
    pps_pkg::pps_status_t st;
    assign st = '{counters_held:  counters_load,
                  cp_three_state: cp_three_state,
                  powered_down:   power_down,
                  bias_settled:   (settle_cnt_r == 4'h0) && en_s2_r,
                  init_armed:     init_armed_r};

    logic req;
    assign req = avs_read || avs_write;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_ack_r       <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else if (clk_en)
        begin
            avs_ack_r       <= req && !avs_ack_r;
            avs_waitrequest <= !(req && !avs_ack_r);
            if (req && !avs_ack_r && avs_read)
            begin
                unique case (avs_address)
                    pps_pkg::ADR_STATUS: avs_readdata <= {27'h0, st};
                    pps_pkg::ADR_FUNC:   avs_readdata <= {8'h0, func_latch_r};
                    pps_pkg::ADR_REF:    avs_readdata <= {8'h0, ref_latch_r};
                    pps_pkg::ADR_NCNT:   avs_readdata <= {8'h0, ncnt_latch_r};
                    default:             avs_readdata <= pps_pkg::BAD_ADR_DATA;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### verilog/pps_pkg.sv
`default_nettype none
package pps_pkg;
    // serial word
    localparam int          WORD_BITS       = 24;
    localparam int          CTRL_LSB        = 0;
    localparam logic [1:0]  SEL_REF         = 2'h0;
    localparam logic [1:0]  SEL_NCNT        = 2'h1;
    localparam logic [1:0]  SEL_FUNC        = 2'h2;
    localparam logic [1:0]  SEL_INIT        = 2'h3;
    // function / initialization word fields
    localparam int          CRST_POS        = 2;
    localparam int          PDA_POS         = 3;
    localparam int          MON_LSB         = 4;
    localparam int          CPTRI_POS       = 8;
    localparam int          PDB_POS         = 19;
    localparam logic [23:0] LATCH_RST       = 24'h000000;
    // internal reset pulse length and bias settle time
    localparam int          PULSE_CYC       = 2;
    localparam int          SETTLE_NS       = 1000;
    localparam int          CLK_NS          = 100;
    localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // monitor selections
    localparam logic [2:0]  MON_LOW         = 3'h0;
    localparam logic [2:0]  MON_LOCK        = 3'h1;
    localparam logic [2:0]  MON_NDIV        = 3'h2;
    localparam logic [2:0]  MON_RDIV        = 3'h4;
    localparam logic [2:0]  MON_HIGH        = 3'h7;
    // avalon register map
    localparam logic [3:0]  ADR_STATUS      = 4'h0;
    localparam logic [3:0]  ADR_FUNC        = 4'h1;
    localparam logic [3:0]  ADR_REF         = 4'h2;
    localparam logic [3:0]  ADR_NCNT        = 4'h3;
    localparam logic [31:0] BAD_ADR_DATA    = 32'h00000000;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic strobe;
    } pps_serial_t;

    typedef struct packed {
        logic counters_held;
        logic cp_three_state;
        logic powered_down;
        logic bias_settled;
        logic init_armed;
    } pps_status_t;
endpackage
`default_nettype wire

// ### verification/pps_sequencer_sva.sv
`default_nettype none
module pps_sequencer_sva
(
    input wire logic                 ref_clk,
    input wire logic                 arst_n,
    input wire pps_pkg::pps_serial_t serial_in,
    input wire logic                 power_enable,
    input wire logic [3:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire logic                 counters_load,
    input wire logic                 cp_three_state,
    input wire logic                 power_down,
    input wire logic                 prescaler_ref_on,
    input wire logic                 osc_buffer_on,
    input wire logic [23:0]          ref_latch,
    input wire logic [23:0]          ncnt_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // ========
    // checks
    a_ref_stays_on: assert property (!power_down && !$past(power_down) && !$past(power_down, 2)
        |-> prescaler_ref_on && osc_buffer_on) else $error("reference or buffer off while powered");
    a_pd_holds_counters: assert property (power_down && $past(power_down)
        |-> counters_load && cp_three_state) else $error("power-down without counter hold");
    a_enable_low_pd: assert property (!power_enable [*4] |-> power_down) else $error("enable low, no power-down");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("late answer");
    a_bad_adr_zero: assert property (!avs_waitrequest && avs_read && avs_address > 4'h3
        |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
    a_ref_readback: assert property (!avs_waitrequest && avs_read && avs_address == pps_pkg::ADR_REF
        |-> avs_readdata == {8'h00, ref_latch}) else $error("reference readback differs");
    a_latch_on_strobe: assert property ($changed(ref_latch) || $changed(ncnt_latch)
        |-> serial_in.strobe) else $error("latch changed without strobe");
    cover property ($rose(counters_load) && !power_down);
    cover property ($rose(power_down));
    cover property (!avs_waitrequest && avs_read);
endmodule
bind pps_sequencer pps_sequencer_sva pps_sequencer_sva_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .serial_in(serial_in), .power_enable(power_enable), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .counters_load(counters_load), .cp_three_state(cp_three_state), .power_down(power_down),
    .prescaler_ref_on(prescaler_ref_on), .osc_buffer_on(osc_buffer_on), .ref_latch(ref_latch),
    .ncnt_latch(ncnt_latch));
`default_nettype wire

// ### verification/pps_host_model.sv
`default_nettype none
module pps_host_model
(
    input  wire logic                ref_clk,
    input  wire logic                counters_load,
    output var pps_pkg::pps_serial_t serial_out,
    output var logic                 power_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        serial_out = '0;
        power_enable = 1'b1;
    end
    // ========
    // serial word, msb first, 800 ns clock only inside frames
    task automatic send(input logic [23:0] word, output int hi);
        hi = 0;
        @(posedge ref_clk);
        for (int i = 23; i >= 0; i--)
        begin
            // data moves with the falling clock, keeping the period at 8 ref_clk cycles
            serial_out.sdata <= word[i];
            repeat (4) @(posedge ref_clk);
            serial_out.sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            serial_out.sclk <= 1'b0;
        end
        @(posedge ref_clk);
        serial_out.sdata <= ~word[0];
        serial_out.strobe <= 1'b1;
        repeat (12)
        begin
            @(posedge ref_clk);
            if (counters_load === 1'b1)
                hi++;
        end
        serial_out.strobe <= 1'b0;
    endtask
    task automatic set_enable(input logic v);
        @(posedge ref_clk);
        power_enable <= v;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_pps_sequencer.sv
`default_nettype none
module tb_pps_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 ref_clk, arst_n, power_enable, lock_indication, avs_read, avs_write;
    logic [3:0]           avs_address;
    logic [31:0]          avs_writedata, avs_readdata, d;
    logic                 avs_waitrequest, counters_load, cp_three_state, power_down;
    logic                 prescaler_ref_on, osc_buffer_on, monitor_output_pin;
    logic [23:0]          ref_latch, ncnt_latch;
    logic                 clk_en, cp_event, ndiv_out, rdiv_out;
    pps_pkg::pps_serial_t serial;
    int                   errors = 0, checked = 0, hi;
    pps_sequencer pps_sequencer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .serial_in(serial),
        .power_enable(power_enable), .lock_indication(lock_indication), .cp_event(cp_event), .ndiv_out(ndiv_out),
        .rdiv_out(rdiv_out), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .counters_load(counters_load), .cp_three_state(cp_three_state), .power_down(power_down),
        .prescaler_ref_on(prescaler_ref_on), .osc_buffer_on(osc_buffer_on),
        .monitor_output_pin(monitor_output_pin), .ref_latch(ref_latch), .ncnt_latch(ncnt_latch));
    pps_host_model pps_host_model_inst (.ref_clk(ref_clk), .counters_load(counters_load), .serial_out(serial),
        .power_enable(power_enable));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // ========
    // shared tasks
    task automatic final_report();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= 32'h00abcdef;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            final_report();
        end
    endtask
    // ========
    // scenarios
    task automatic t_reset_bus();
        bus(1'b0, pps_pkg::ADR_FUNC, d);
        chk("func after reset", 32'h0, d);
        bus(1'b1, pps_pkg::ADR_REF, d);
        bus(1'b0, pps_pkg::ADR_REF, d);
        chk("ref after write", 32'h0, d);
        bus(1'b0, 4'h9, d);
        chk("unmapped", 32'h0, d);
        chk("power_down", 32'h0, 32'(power_down));
        $display("test reset_bus done");
    endtask
    task automatic t_init_method();
        pps_host_model_inst.send(24'h000013, hi);
        chk("init pulse", 32'h3, 32'(hi));
        chk("prescaler ref", 32'h1, 32'(prescaler_ref_on));
        bus(1'b0, pps_pkg::ADR_FUNC, d);
        chk("func from init", 32'h000013, d);
        pps_host_model_inst.send(24'h000500, hi);
        chk("ref pulse", 32'h0, 32'(hi));
        chk("ref latch", 32'h000500, 32'(ref_latch));
        pps_host_model_inst.send(24'h012341, hi);
        chk("first n pulse", 32'h3, 32'(hi));
        chk("n latch", 32'h012341, 32'(ncnt_latch));
        pps_host_model_inst.send(24'h012345, hi);
        chk("later n pulse", 32'h0, 32'(hi));
        $display("test init_method done");
    endtask
    task automatic t_counter_reset();
        pps_host_model_inst.send(24'h000006, hi);
        repeat (20) @(posedge ref_clk);
        chk("counters held", 32'h1, 32'(counters_load));
        chk("pump three-state", 32'h1, 32'(cp_three_state));
        chk("no power-down", 32'h0, 32'(power_down));
        pps_host_model_inst.send(24'h000500, hi);
        pps_host_model_inst.send(24'h012341, hi);
        pps_host_model_inst.send(24'h000012, hi);
        repeat (4) @(posedge ref_clk);
        chk("counters released", 32'h0, 32'(counters_load));
        bus(1'b0, pps_pkg::ADR_FUNC, d);
        chk("func latch", 32'h000012, d);
        lock_indication <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("monitor high", 32'h1, 32'(monitor_output_pin));
        lock_indication <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("monitor low", 32'h0, 32'(monitor_output_pin));
        $display("test counter_reset done");
    endtask
    task automatic t_enable_pin();
        pps_host_model_inst.set_enable(1'b0);
        repeat (4) @(posedge ref_clk);
        chk("power_down", 32'h1, 32'(power_down));
        pps_host_model_inst.send(24'h000012, hi);
        pps_host_model_inst.send(24'h000a00, hi);
        pps_host_model_inst.send(24'h00abc1, hi);
        pps_host_model_inst.set_enable(1'b1);
        repeat (pps_pkg::SETTLE_CYC) @(posedge ref_clk);
        chk("powered", 32'h0, 32'(power_down));
        chk("counters run", 32'h0, 32'(counters_load));
        pps_host_model_inst.set_enable(1'b0);
        repeat (8) @(posedge ref_clk);
        pps_host_model_inst.set_enable(1'b1);
        repeat (pps_pkg::SETTLE_CYC) @(posedge ref_clk);
        chk("ref kept", 32'h000a00, 32'(ref_latch));
        chk("n kept", 32'h00abc1, 32'(ncnt_latch));
        $display("test enable_pin done");
    endtask
    task automatic t_sync_pd();
        pps_host_model_inst.send(24'h08000b, hi);
        chk("sync init pulse", 32'h3, 32'(hi));
        chk("sync pd waits", 32'h0, 32'(power_down));
        bus(1'b0, pps_pkg::ADR_STATUS, d);
        chk("status armed", 32'h00000003, d);
        cp_event <= 1'b1;
        @(posedge ref_clk);
        cp_event <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("sync pd entered", 32'h1, 32'(power_down));
        bus(1'b0, pps_pkg::ADR_STATUS, d);
        chk("status down", 32'h0000001f, d);
        pps_host_model_inst.send(24'h000002, hi);
        chk("sync pd left", 32'h0, 32'(power_down));
        $display("test sync_pd done");
    endtask
    task automatic t_monitor();
        ndiv_out <= 1'b1;
        pps_host_model_inst.send(24'h000022, hi);
        chk("mon ndiv", 32'h1, 32'(monitor_output_pin));
        pps_host_model_inst.send(24'h000042, hi);
        chk("mon rdiv low", 32'h0, 32'(monitor_output_pin));
        rdiv_out <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("mon rdiv", 32'h1, 32'(monitor_output_pin));
        pps_host_model_inst.send(24'h000002, hi);
        chk("mon off", 32'h0, 32'(monitor_output_pin));
        pps_host_model_inst.send(24'h000072, hi);
        chk("mon fixed high", 32'h1, 32'(monitor_output_pin));
        ndiv_out <= 1'b0;
        rdiv_out <= 1'b0;
        $display("test monitor done");
    endtask
    task automatic t_freeze();
        clk_en <= 1'b0;
        pps_host_model_inst.send(24'h000700, hi);
        chk("frozen ref", 32'h000a00, 32'(ref_latch));
        clk_en <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("thawed ref", 32'h000a00, 32'(ref_latch));
        $display("test freeze done");
    endtask
    initial
    begin
        arst_n = 1'b0;
        lock_indication = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        clk_en = 1'b1;
        cp_event = 1'b0;
        ndiv_out = 1'b0;
        rdiv_out = 1'b0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset_bus();
        t_init_method();
        t_counter_reset();
        t_enable_pin();
        t_sync_pd();
        t_monitor();
        t_freeze();
        final_report();
    end
endmodule
`default_nettype wire
